// ==== verilog/icap_top.sv ====
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module icap_top
  import icap_pkg::*;
#(
  parameter int unsigned NCH = MAX_CH
)(
  input wire logic core_clk,                    // 250 MHz clock
  input wire logic sys_rst,                     // Sync reset, high
  input wire logic psel,                        // APB select
  input wire logic penable,                     // APB enable
  input wire logic pwrite,                      // APB direction
  input wire logic [ADDR_W-1:0] paddr,          // APB byte address
  input wire logic [31:0] pwdata,               // APB write data
  output logic [31:0] prdata,                   // APB read data
  output logic pready,                          // APB ready
  output logic pslverr,                         // Unmapped access
  input wire logic [NCH-1:0] capture_input_pin, // Capture inputs
  input wire logic [1:0] timer_ext_clock_pin,   // Ext clock/gate A, B
  input wire logic cpu_idle,                    // Device in Idle
  input wire logic cpu_sleep,                   // Device in Sleep
  output logic [NCH-1:0] capture_irq,           // Per-channel interrupts
  output logic [1:0] dma_req,                   // DMA, channels 0-1
  output logic wake_req                         // Wake from low power
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // DMA needs two channels; the map only has room for eight
  initial begin
    if (NCH < 2 || NCH > MAX_CH) $error("NCH must be 2..8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] tcon_a_reg;
  logic [15:0] tcon_b_reg;
  logic [15:0] ch_ctl_reg [NCH];
  logic [15:0] tcnt_a;
  logic [15:0] tcnt_b;
  logic [NCH-1:0] ch_irq;
  logic [NCH-1:0] ch_wake;
  logic [NCH-1:0] pop_reg;
  logic [NCH-1:0] pop_next;
  logic access;
  logic prep;
  logic done;
  logic wr_done;
  logic [ADDR_W-1:0] ch_off;
  logic [2:0] ch_idx;
  logic ch_hit;
  logic buf_sel;
  logic mapped;
  logic [31:0] rd_next;
  logic tcnt_a_wr;
  logic tcnt_b_wr;
  logic [15:0] chif_head [NCH];
  logic [NCH-1:0] chif_bne;
  logic [NCH-1:0] chif_ov;

  icap_ch_if chif [NCH] ();

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // One wait state lets read data and pop intent settle from flops
  assign access = psel & penable;
  assign prep = access & !pready;
  assign done = access & pready;
  assign wr_done = done & pwrite;

  always_ff @(posedge core_clk) begin
    if (sys_rst) pready <= 1'b0;
    else pready <= prep;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Channels sit at base + 8*n: control word, then buffer word
  assign ch_off = paddr - OFF_CH_BASE;
  assign ch_idx = ch_off[CH_STRIDE_LOG2 +: 3];
  assign buf_sel = ch_off[CH_SUB_BIT];
  assign ch_hit = (paddr >= OFF_CH_BASE) && (paddr[1:0] == 2'h0)
    && (ch_off < ADDR_W'(NCH << CH_STRIDE_LOG2));
  assign mapped = ch_hit || paddr == OFF_TCON_A || paddr == OFF_TCON_B
    || paddr == OFF_TCNT_A || paddr == OFF_TCNT_B;

  // ----------------------------------------------------------------
  // Read mux and pop intent
  // ----------------------------------------------------------------
  // Pop is decided when data is sampled, so a capture landing between
  // the two access cycles can never be popped unseen
  always_comb begin
    rd_next = 32'h0000_0000;
    pop_next = '0;
    if (paddr == OFF_TCON_A) rd_next = {16'h0000, tcon_a_reg};
    else if (paddr == OFF_TCON_B) rd_next = {16'h0000, tcon_b_reg};
    else if (paddr == OFF_TCNT_A) rd_next = {16'h0000, tcnt_a};
    else if (paddr == OFF_TCNT_B) rd_next = {16'h0000, tcnt_b};
    else if (ch_hit) begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_idx == 3'(i)) begin
          if (buf_sel) begin
            rd_next = {16'h0000, chif_head[i]};
            pop_next[i] = !pwrite & chif_bne[i];
          end else begin
            rd_next = {16'h0000, ch_ctl_reg[i]};
            rd_next[CC_OV] = chif_ov[i];
            rd_next[CC_BNE] = chif_bne[i];
          end
        end
      end
    end
  end

  // Read data and error captured in the wait state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (prep) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_next;
      pslverr <= !mapped;
    end
  end

  // Pop intent held until the completing edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) pop_reg <= '0;
    else if (prep) pop_reg <= pop_next;
    else if (done) pop_reg <= '0;
  end

  // ----------------------------------------------------------------
  // Timer control registers
  // ----------------------------------------------------------------
  // Unimplemented bits are masked so they read as zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) tcon_a_reg <= TCON_RESET;
    else if (wr_done && paddr == OFF_TCON_A) tcon_a_reg <= pwdata[15:0] & TCON_A_WMASK;
  end

  // Second time base control; its run bit gates the counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) tcon_b_reg <= TCON_RESET;
    else if (wr_done && paddr == OFF_TCON_B) tcon_b_reg <= pwdata[15:0] & TCON_B_WMASK;
  end

  assign tcnt_a_wr = wr_done && paddr == OFF_TCNT_A;
  assign tcnt_b_wr = wr_done && paddr == OFF_TCNT_B;

  // ----------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------
  // Pair mode bit is stored only; each time base counts 16 bits.
  // Software keeps idle halt clear when pairing for Idle.
  icap_timer u_time_base_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ctl(tcon_a_reg),
    .cnt_wr(tcnt_a_wr),
    .cnt_wdata(pwdata[15:0]),
    .ext_pin(timer_ext_clock_pin[0]),
    .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep),
    .count(tcnt_a)
  );

  // Second time base with its own pin and prescaler
  icap_timer u_time_base_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ctl(tcon_b_reg),
    .cnt_wr(tcnt_b_wr),
    .cnt_wdata(pwdata[15:0]),
    .ext_pin(timer_ext_clock_pin[1]),
    .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep),
    .count(tcnt_b)
  );

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // Channel control word; status bits are read-only
    always_ff @(posedge core_clk) begin
      if (sys_rst) ch_ctl_reg[g] <= CC_RESET;
      else if (wr_done && ch_hit && !buf_sel && ch_idx == 3'(g)) begin
        ch_ctl_reg[g] <= pwdata[15:0] & CC_WMASK;
      end
    end

    assign chif[g].ctl = ch_ctl_reg[g];
    assign chif[g].pop = pop_reg[g] & done;
    assign chif_head[g] = chif[g].head;
    assign chif_bne[g] = chif[g].bne;
    assign chif_ov[g] = chif[g].ov;
    assign ch_irq[g] = chif[g].irq;
    assign ch_wake[g] = chif[g].wake;

    icap_chan #(
      .DEPTH(FIFO_DEPTH)
    ) u_chan (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .pin(capture_input_pin[g]),
      .tb_a(tcnt_a),
      .tb_b(tcnt_b),
      .cpu_idle(cpu_idle),
      .cpu_sleep(cpu_sleep),
      .ch(chif[g])
    );
  end

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  // Each channel drives its own interrupt line, usable as an
  // extra external interrupt source
  always_ff @(posedge core_clk) begin
    if (sys_rst) capture_irq <= '0;
    else capture_irq <= ch_irq;
  end

  // Only the first two channels reach DMA; software sets one
  // capture per interrupt so each request moves one word
  always_ff @(posedge core_clk) begin
    if (sys_rst) dma_req <= 2'h0;
    else dma_req <= ch_irq[1:0];
  end

  // Any channel event in Sleep or Idle asks for wake-up
  always_ff @(posedge core_clk) begin
    if (sys_rst) wake_req <= 1'b0;
    else wake_req <= |ch_wake;
  end

endmodule : icap_top
`default_nettype wire

// ==== include/icap_pkg.sv ====
package icap_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_TCON_A = 12'h000;
  localparam logic [11:0] OFF_TCON_B = 12'h004;
  localparam logic [11:0] OFF_TCNT_A = 12'h008;
  localparam logic [11:0] OFF_TCNT_B = 12'h00C;
  localparam logic [11:0] OFF_CH_BASE = 12'h010;
  localparam int unsigned CH_STRIDE_LOG2 = 3;
  localparam int unsigned CH_SUB_BIT = 2;
  localparam int unsigned MAX_CH = 8;

  // ----------------------------------------------------------------
  // Timer control fields
  // ----------------------------------------------------------------
  localparam int unsigned TC_RUN = 15;
  localparam int unsigned TC_IDLE = 13;
  localparam int unsigned TC_GATE = 6;
  localparam int unsigned TC_PS_LO = 4;
  localparam int unsigned TC_PAIR = 3;
  localparam int unsigned TC_CS = 1;
  localparam logic [15:0] TCON_A_WMASK = 16'hA07A;
  localparam logic [15:0] TCON_B_WMASK = 16'hA072;
  localparam logic [15:0] TCON_RESET = 16'h0000;
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
  localparam logic [7:0] PS_LIM_DIV1 = 8'h00;
  localparam logic [7:0] PS_LIM_DIV8 = 8'h07;
  localparam logic [7:0] PS_LIM_DIV64 = 8'h3F;
  localparam logic [7:0] PS_LIM_DIV256 = 8'hFF;

  // ----------------------------------------------------------------
  // Capture channel control fields and mode codes
  // ----------------------------------------------------------------
  localparam int unsigned CC_SIDL = 13;
  localparam int unsigned CC_TSEL = 7;
  localparam int unsigned CC_ICI_LO = 5;
  localparam int unsigned CC_OV = 4;
  localparam int unsigned CC_BNE = 3;
  localparam logic [15:0] CC_WMASK = 16'h20E7;
  localparam logic [15:0] CC_RESET = 16'h0000;
  localparam logic [2:0] CM_OFF = 3'h0;
  localparam logic [2:0] CM_BOTH = 3'h1;
  localparam logic [2:0] CM_FALL = 3'h2;
  localparam logic [2:0] CM_RISE = 3'h3;
  localparam logic [2:0] CM_RISE4 = 3'h4;
  localparam logic [2:0] CM_RISE16 = 3'h5;
  localparam logic [2:0] CM_WAKE = 3'h7;
  localparam logic [3:0] CAP_PS_LIM4 = 4'h3;
  localparam logic [3:0] CAP_PS_LIM16 = 4'hF;
  localparam int unsigned FIFO_DEPTH = 4;

endpackage : icap_pkg

// ==== include/icap_ch_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface icap_ch_if;
  logic [15:0] ctl;  // Writable control bits
  logic pop;         // Remove oldest entry
  logic [15:0] head; // Oldest captured value
  logic bne;         // Buffer not empty
  logic ov;          // Overflow seen
  logic irq;         // Interrupt pulse
  logic wake;        // Wake request pulse
  modport ctrl (output ctl, output pop, input head, input bne, input ov, input irq,
    input wake);
  modport chan (input ctl, input pop, output head, output bne, output ov, output irq,
    output wake);
endinterface : icap_ch_if
`default_nettype wire

// ==== verilog/icap_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module icap_timer
  import icap_pkg::*;
(
  input wire logic core_clk,        // System clock
  input wire logic sys_rst,         // Sync reset
  input wire logic [15:0] ctl,      // Timer control word
  input wire logic cnt_wr,          // Load counter
  input wire logic [15:0] cnt_wdata, // Load value
  input wire logic ext_pin,         // External clock / gate pin
  input wire logic cpu_idle,        // Device in Idle
  input wire logic cpu_sleep,       // Device in Sleep
  output logic [15:0] count         // Counter value
);
  logic ext_prev_reg;
  logic [7:0] ps_reg;
  logic [7:0] ps_lim;
  logic halted;
  logic tick;

  // Prescale limit per code
  always_comb begin
    case (ctl[TC_PS_LO +: 2])
      PS_DIV1: ps_lim = PS_LIM_DIV1;
      PS_DIV8: ps_lim = PS_LIM_DIV8;
      PS_DIV64: ps_lim = PS_LIM_DIV64;
      default: ps_lim = PS_LIM_DIV256;
    endcase
  end

  // Run, idle halt; internal clock stops in Sleep
  assign halted = !ctl[TC_RUN] | (cpu_idle & ctl[TC_IDLE])
    | (cpu_sleep & !ctl[TC_CS]);
  // Pin edge when external, gate level ignored then
  assign tick = ctl[TC_CS] ? (ext_pin & !ext_prev_reg)
    : (ctl[TC_GATE] ? ext_pin : 1'b1);

  // Pin history for edge detection
  always_ff @(posedge core_clk) begin
    if (sys_rst) ext_prev_reg <= 1'b0;
    else ext_prev_reg <= ext_pin;
  end

  // Prescaler and counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ps_reg <= 8'h00;
      count <= 16'h0000;
    end else begin
      if (!ctl[TC_RUN]) ps_reg <= 8'h00;
      else if (!halted && tick) begin
        if (ps_reg >= ps_lim) ps_reg <= 8'h00;
        else ps_reg <= ps_reg + 8'h01;
      end
      if (cnt_wr) count <= cnt_wdata;
      else if (!halted && tick && ps_reg >= ps_lim) count <= count + 16'h0001;
    end
  end
endmodule : icap_timer
`default_nettype wire

// ==== verilog/icap_chan.sv ====
`timescale 1ns/10ps
`default_nettype none
module icap_chan
  import icap_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input wire logic core_clk,    // System clock
  input wire logic sys_rst,     // Sync reset
  input wire logic pin,         // Capture input
  input wire logic [15:0] tb_a, // Time base A
  input wire logic [15:0] tb_b, // Time base B
  input wire logic cpu_idle,    // Device in Idle
  input wire logic cpu_sleep,   // Device in Sleep
  icap_ch_if.chan ch            // Control side
);
  localparam int unsigned PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic pin_prev_reg;
  logic [3:0] cps_reg;
  logic [1:0] ici_reg;
  logic [15:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic ov_reg;
  logic [2:0] mode;
  logic rise, fall, lowpow, active, hit, cap, full, push, pop, irq7;

  assign mode = ch.ctl[2:0];
  assign rise = pin & !pin_prev_reg;
  assign fall = !pin & pin_prev_reg;
  assign lowpow = cpu_idle | cpu_sleep;
  assign full = (cnt_reg == (PW+1)'(DEPTH));
  assign active = !(cpu_idle & ch.ctl[CC_SIDL]);

  // Event qualification per mode
  always_comb begin
    case (mode)
      CM_BOTH: hit = rise | fall;
      CM_FALL: hit = fall;
      CM_RISE: hit = rise;
      CM_RISE4: hit = rise && cps_reg == CAP_PS_LIM4;
      CM_RISE16: hit = rise && cps_reg == CAP_PS_LIM16;
      default: hit = 1'b0;
    endcase
  end
  assign cap = active & hit;
  assign push = cap & !full;
  assign pop = ch.pop & (cnt_reg != '0);
  assign irq7 = (mode == CM_WAKE) & lowpow & rise;

  // Edge history and capture prescaler
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_prev_reg <= 1'b0;
      cps_reg <= 4'h0;
    end else begin
      pin_prev_reg <= pin;
      if (mode != CM_RISE4 && mode != CM_RISE16) cps_reg <= 4'h0;
      else if (rise && active) begin
        if (hit) cps_reg <= 4'h0;
        else cps_reg <= cps_reg + 4'h1;
      end
    end
  end

  // FIFO, oldest first; full FIFO keeps its entries
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= ch.ctl[CC_TSEL] ? tb_a : tb_b;
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Overflow: set wins over the clear by mode off
  always_ff @(posedge core_clk) begin
    if (sys_rst) ov_reg <= 1'b0;
    else if (cap && full) ov_reg <= 1'b1;
    else if (mode == CM_OFF) ov_reg <= 1'b0;
  end

  // Captures-per-interrupt counter
  always_ff @(posedge core_clk) begin
    if (sys_rst || mode == CM_OFF) ici_reg <= 2'h0;
    else if (cap) begin
      if (ici_reg == ch.ctl[CC_ICI_LO +: 2]) ici_reg <= 2'h0;
      else ici_reg <= ici_reg + 2'h1;
    end
  end

  assign ch.irq = irq7 | (cap & (mode == CM_BOTH
    || ici_reg == ch.ctl[CC_ICI_LO +: 2]));
  assign ch.wake = lowpow & (cap | irq7);
  assign ch.head = mem_reg[rp_reg];
  assign ch.bne = (cnt_reg != '0);
  assign ch.ov = ov_reg;
endmodule : icap_chan
`default_nettype wire

// ==== bench/icap_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module icap_checker
  import icap_pkg::*;
#(
  parameter int unsigned NCH = MAX_CH
)(
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [NCH-1:0] capture_input_pin, // Pins
  input wire logic [1:0] timer_ext_clock_pin, // Ext clocks
  input wire logic cpu_idle, // Idle
  input wire logic cpu_sleep, // Sleep
  input wire logic [NCH-1:0] capture_irq, // Interrupts
  input wire logic [1:0] dma_req, // DMA
  input wire logic wake_req // Wake
);
  logic [5:0] pin_h; // Recent levels of pin 0
  logic [1:0] lp_h; // Recent low-power state
  // ----
  // History
  // ----
  // Kept short so a slow answer shows up as a failure
  always_ff @(posedge core_clk) begin
    pin_h <= {pin_h[4:0], capture_input_pin[0]};
    lp_h <= {lp_h[0], cpu_idle | cpu_sleep};
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_first; psel && penable && !pready; endsequence
  a_apb_one_wait: assert property (s_setup ##1 s_first |=> pready)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_dma_mirror: assert property (dma_req == capture_irq[1:0])
    else $error("dma request differs from irq");
  a_irq_edge: assert property (capture_irq[0] |-> (pin_h[5:1] ^ pin_h[4:0]) != 5'h00)
    else $error("irq without pin edge");
  a_wake_lowpow: assert property (wake_req |-> lp_h != 2'h0)
    else $error("wake outside low power");
endmodule : icap_checker
bind icap_top icap_checker #(.NCH(NCH)) i_chk (.*);
`default_nettype wire

// ==== bench/icap_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module icap_pin_model (
  input wire logic core_clk, // Clock
  input wire logic [7:0] tgl, // Toggle request
  output logic [7:0] pins // Pin levels
);
  // Pins driven push-pull, so levels hold between edges
  initial pins = 8'h00;
  always @(posedge core_clk) pins <= pins ^ tgl;
endmodule : icap_pin_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import icap_pkg::*;
  // ----
  // Signals and instances
  // ----
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, er, wake, cpu_idle = 1'b0, cpu_sleep = 1'b0;
  logic [7:0] tgl = 8'h00, pins, irq;
  logic [1:0] ext = 2'h0, dma;
  int bad_count = 0, check_count = 0, dma_n = 0, wake_n = 0, b;
  int irq_n [8];
  icap_pin_model i_pins (.core_clk(core_clk), .tgl(tgl), .pins(pins));
  icap_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_pin(pins), .timer_ext_clock_pin(ext),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .capture_irq(irq), .dma_req(dma),
    .wake_req(wake));
  initial forever #2 core_clk = ~core_clk;
  // Pulse counters, read as differences to avoid racing the monitor
  always @(posedge core_clk) if (!sys_rst) begin
    for (int i = 0; i < 8; i++) irq_n[i] += irq[i];
    dma_n += dma[0] + dma[1];
    wake_n += wake;
  end
  // ----
  // Bus and check tasks
  // ----
  task results;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Request held until ready is sampled high
  // Waits as long as the slave needs; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [15:0] d); apb(1'b1, a, d); endtask : wr
  task rd(input logic [11:0] a); apb(1'b0, a, 16'h0000); endtask : rd
  function logic [11:0] ca(input int c); return 12'(16 + c * 8); endfunction : ca
  // Edges come far apart, well inside one capture per cycle
  task pulse(input int c, input int n);
    repeat (2 * n) begin tgl[c] <= 1'b1; cyc(1); tgl <= 8'h00; cyc(3); end
    cyc(3);
  endtask : pulse
  task drain(input int c, input logic [15:0] v, input logic [15:0] st, input int ne);
    int n;
    n = 0;
    rd(ca(c));
    while (rv[CC_BNE] === 1'b1 && n < 6) begin
      rd(ca(c) + 12'h004);
      chk(rv, {16'h0000, v});
      v = v + st; n++; rd(ca(c));
    end
    chk(n, ne);
  endtask : drain
  // ----
  // Scenarios
  // ----
  task t_regs;
    rd(OFF_TCON_B); chk(rv, 0);
    rd(ca(0)); chk(rv, 0);
    wr(ca(0), 16'h0018); rd(ca(0)); chk(rv, 0);
    rd(12'hFF0); chk({31'h0, er}, 1);
    chk(rv, 0);
  endtask : t_regs
  task t_timer;
    logic [15:0] e;
    for (int ps = 0; ps < 4; ps++) begin
      wr(OFF_TCNT_B, 16'h0000); wr(OFF_TCON_B, 16'h8000 | 16'(ps << 4));
      cyc(1021); wr(OFF_TCON_B, 16'h0000);
      e = 16'(1024 >> (ps == 3 ? 8 : 3 * ps)); rd(OFF_TCNT_B);
      chk(rv[15:0] + 16'h0001 >= e && rv[15:0] <= e + 16'h0001, 1);
    end
    e = rv[15:0]; cyc(20); rd(OFF_TCNT_B); chk(rv, {16'h0000, e});
    wr(OFF_TCNT_B, 16'h0000); wr(OFF_TCON_B, 16'h8042);
    repeat (10) begin ext[1] <= 1'b1; cyc(3); ext[1] <= 1'b0; cyc(3); end
    wr(OFF_TCON_B, 16'h0000); rd(OFF_TCNT_B); chk(rv, 10);
    wr(OFF_TCNT_B, 16'h0000); wr(OFF_TCON_B, 16'h8040); cyc(50);
    ext[1] <= 1'b1; cyc(100); ext[1] <= 1'b0; cyc(10); rd(OFF_TCNT_B);
    chk(rv >= 97 && rv <= 103, 1);
    wr(OFF_TCON_B, 16'h0000);
  endtask : t_timer
  task t_modes;
    logic [2:0] md [8];
    int np [8];
    int ne [8];
    md = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h0, 3'h4, 3'h4, 3'h5};
    np = '{1, 1, 1, 1, 1, 3, 4, 16};
    ne = '{2, 1, 1, 0, 0, 0, 1, 1};
    wr(OFF_TCNT_A, 16'h00AB); wr(OFF_TCNT_B, 16'h1234);
    for (int i = 0; i < 8; i++) begin
      wr(ca(0), 16'h0000); wr(ca(0), 16'(md[i]) | (i % 2 ? 16'h0080 : 16'h0000));
      pulse(0, np[i]);
      drain(0, i % 2 ? 16'h00AB : 16'h1234, 16'h0000, ne[i]);
    end
    wr(ca(0), 16'h0003);
    for (int k = 1; k < 4; k++) begin wr(OFF_TCNT_B, 16'(k)); pulse(0, 1); end
    drain(0, 16'h0001, 16'h0001, 3);
  endtask : t_modes
  task t_irq;
    int bd;
    for (int captures_per_irq = 0; captures_per_irq < 4; captures_per_irq++) begin
      wr(ca(0), 16'h0000); b = irq_n[0]; bd = dma_n;
      wr(ca(0), 16'h0003 | 16'(captures_per_irq << 5)); pulse(0, 4);
      chk(irq_n[0] - b, 4 / (captures_per_irq + 1));
      chk(dma_n - bd, 4 / (captures_per_irq + 1));
      drain(0, 16'h0003, 16'h0000, 4);
    end
    wr(ca(0), 16'h0000); b = irq_n[0]; wr(ca(0), 16'h0061); pulse(0, 1);
    chk(irq_n[0] - b, 2);
    drain(0, 16'h0003, 16'h0000, 2);
    b = dma_n; bd = irq_n[7]; wr(ca(7), 16'h0003); pulse(7, 5); rd(ca(7));
    chk(rv[4:3], 2'b11);
    chk(dma_n - b, 0);
    chk(irq_n[7] - bd, 5);
    drain(7, 16'h0003, 16'h0000, 4);
    rd(ca(7)); chk(rv[4], 1'b1);
    wr(ca(7), 16'h0000); rd(ca(7)); chk(rv[4], 1'b0);
  endtask : t_irq
  task t_wake;
    logic [15:0] e;
    wr(ca(1), 16'h0007); b = wake_n; cpu_idle <= 1'b1; cyc(2); pulse(1, 1);
    chk(wake_n - b, 1);
    rd(ca(1)); chk(rv[3], 1'b0);
    wr(OFF_TCON_A, 16'hA000); rd(OFF_TCNT_A); e = rv[15:0]; cyc(30);
    rd(OFF_TCNT_A); chk(rv, {16'h0000, e});
    wr(OFF_TCON_A, 16'h8008); cyc(30); rd(OFF_TCNT_A);
    chk(rv[15:0] - e >= 30 && rv[15:0] - e <= 34, 1);
    cpu_idle <= 1'b0; cyc(2); pulse(1, 1);
    chk(wake_n - b, 1);
    cpu_sleep <= 1'b1; cyc(2); pulse(1, 1);
    chk(wake_n - b, 2);
    cpu_sleep <= 1'b0;
    wr(OFF_TCON_A, 16'h0000);
  endtask : t_wake
  // ----
  // Run
  // ----
  initial begin
    cyc(16); sys_rst <= 1'b0; cyc(1);
    t_regs; t_timer; t_modes; t_irq; t_wake;
    results;
  end
  // Whole run is near 5600 cycles; this bound of 50000 cycles is far beyond it
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule : tb
`default_nettype wire
